// ==== hw/apr_pkg.sv ====
// shared types of the audio port reset and bring-up block
package apr_pkg;
  typedef struct packed {
    logic fs;
    logic sm;
    logic sr;
    logic bc;
    logic hf;
  } apr_half_s;
  typedef struct packed {
    logic enable;
    logic order;
    logic [1:0] mode;
  } apr_loop_s;
  typedef enum logic [1:0] {
    APR_FR_IDLE = 2'b00,
    APR_FR_ARMED = 2'b01,
    APR_FR_RUN = 2'b11
  } apr_frame_e;
endpackage

// ==== hw/apr_regs.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef APR_REGS_SVH
`define APR_REGS_SVH
`define APR_OFF_GLOBAL 12'h044
`define APR_OFF_RX_ALIAS 12'h060
`define APR_OFF_TX_ALIAS 12'h0A0
`define APR_OFF_LOOPBACK 12'h04C
`define APR_OFF_PINDIR 12'h014
`define APR_OFF_TXBITCLK 12'h0B0
`define APR_OFF_RXFSYNC 12'h068
`define APR_OFF_TXFSYNC 12'h0A8
`define APR_OFF_TXHF 12'h0B4
`define APR_OFF_TXSTAT 12'h0C0
`define APR_OFF_TXBUF 12'h0C4
`define APR_OFF_STATE 12'h0C8
// global control field positions, rx half in [4:0], tx half in [12:8]
`define APR_B_HF 0
`define APR_B_BC 1
`define APR_B_SR 2
`define APR_B_SM 3
`define APR_B_FS 4
`define APR_TX_SHIFT 8
// loopback control fields
`define APR_LB_EN 0
`define APR_LB_ORD 1
`define APR_LB_MODE_LO 2
`define APR_LB_MODE_TX 2'b01
// pin direction bits
`define APR_PD_TXBC 0
`define APR_PD_TXFS 1
`define APR_PD_RXBC 2
`define APR_PD_RXFS 3
// tx bit clock control: divider [4:0], independent select [5]
`define APR_BC_TXRX_INDEPENDENT_SELECT 5
`define APR_BC_RESET 32'h0000_0020
`define APR_TDM_MIN 9'h002
`define APR_TDM_MAX 9'h020
`define APR_HF_RESET 12'h000
`define APR_TXDR_BIT 5
`endif

// ==== hw/apr_section.sv ====
// one half of the port: bit-clock edge finder, control recognition, frame start
`timescale 1ns/10ps
`default_nettype none
module apr_section
  import apr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bit_clock,
  input wire logic frame_sync,
  input wire logic fs_rising,
  input wire apr_half_s ctrl,
  output apr_half_s seen,
  output logic bc_edge,
  output logic frame_start,
  output logic running
);
  logic [1:0] pins_s;
  logic bc_d_reg;
  logic fs_d_reg;
  apr_half_s seen_reg;
  apr_half_s seen_next;
  apr_frame_e fr_reg;
  apr_frame_e fr_next;
  logic fs_edge;

  apr_sync #(.WIDTH(2)) u_pins (
    .clk(pclk),
    .rst_n(presetn),
    .d({bit_clock, frame_sync}),
    .q(pins_s)
  );

  assign bc_edge = pins_s[1] & ~bc_d_reg;
  // edge, not level, of the frame sync starts a frame
  assign fs_edge = fs_rising ? (pins_s[0] & ~fs_d_reg) : (~pins_s[0] & fs_d_reg);

  always_comb begin
    seen_next = seen_reg;
    // control is recognised only on a bit-clock edge; a stopped clock freezes it
    if (bc_edge) begin
      seen_next = ctrl;
    end
    fr_next = fr_reg;
    case (fr_reg)
      APR_FR_IDLE: begin
        if (seen_reg.sm && seen_reg.fs) begin
          fr_next = APR_FR_ARMED;
        end
      end
      APR_FR_ARMED: begin
        if (fs_edge) begin
          fr_next = APR_FR_RUN;
        end
      end
      APR_FR_RUN: begin
        fr_next = APR_FR_RUN;
      end
      default: begin
        fr_next = APR_FR_IDLE;
      end
    endcase
    // drop with the recognised control, not a cycle after it
    if (!(seen_next.sm && seen_next.fs)) begin
      fr_next = APR_FR_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bc_d_reg <= 1'b0;
      fs_d_reg <= 1'b0;
      seen_reg <= '0;
      fr_reg <= APR_FR_IDLE;
    end else begin
      bc_d_reg <= pins_s[1];
      fs_d_reg <= pins_s[0];
      seen_reg <= seen_next;
      fr_reg <= fr_next;
    end
  end

  assign seen = seen_reg;
  assign frame_start = (fr_reg == APR_FR_ARMED) && fs_edge;
  assign running = (fr_reg == APR_FR_RUN);

  run_needs_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    running |-> seen_reg.sm && seen_reg.fs) else $error("frame running without release");
  seen_only_on_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    !bc_edge |=> $stable(seen_reg)) else $error("control seen without bit clock edge");
endmodule
`default_nettype wire

// ==== hw/apr_sync.sv ====
// two-stage level synchroniser, one bit per lane
`timescale 1ns/10ps
`default_nettype none
module apr_sync #(
  parameter int WIDTH = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;
  // refused while elaborating, so a bad width never reaches silicon
  if (WIDTH < 1) begin : g_bad_width
    $error("apr_sync width must be positive");
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end
  assign q = q_reg;
endmodule
`default_nettype wire

// ==== hw/apr_top.sv ====
// audio port global reset, bring-up sequencing and loopback routing
`timescale 1ns/10ps
`default_nettype none
`include "apr_regs.svh"
// Function
// - loopback only while enable bit is one
// - mode 01 times both halves from transmit
// - order zero: odd feeds even, else reverse
// - loopback valid only with 2..32 TDM slots
// - half reset acts only with bit clock, save tx hf gate and tx bc/fs generators, which use written bits at once
// - sleep controller reset equals hardware reset
// - hardware reset clears all port state except the tx bit clock independent select, which it sets
// - tx bit clock pin toggles once tx bit clock direction is output and tx bc is released; tx fs pin pulses only if tx fs is also released
// - tx high-frequency divider resets to one, ungated
// - tx serializer release sets ready, dma, interrupt
// - transfers start on first frame sync edge
// - global readback waits for bit-clock recognition
// - aliases read back written value at once
module apr_top
  import apr_pkg::*;
#(
  parameter int SERIALIZERS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sleep_reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_bit_clock,
  input wire logic rx_bit_clock,
  input wire logic tx_hf_clock,
  input wire logic tx_fsync_in,
  input wire logic rx_fsync_in,
  input wire logic [SERIALIZERS-1:0] ser_pin_in,
  input wire logic [SERIALIZERS-1:0] ser_tx_out,
  output logic [SERIALIZERS-1:0] ser_rx_in,
  output logic tx_bit_clock_out,
  output logic tx_bit_clock_oe_n,
  output logic tx_fsync_out,
  output logic tx_fsync_oe_n,
  output logic tx_hf_clock_gated,
  output logic tx_dma_event,
  output logic tx_interrupt,
  output logic tx_frame_start,
  output logic rx_frame_start
);
  // both resets act as one full hardware reset
  logic rst_n;
  assign rst_n = presetn & sleep_reset_n;

  // loopback pairs serializers, so an odd count cannot be routed
  if (SERIALIZERS < 2 || SERIALIZERS % 2 != 0) begin : g_bad_count
    $error("apr_top needs an even number of serializers, at least two");
  end

  apr_half_s rx_ctrl_reg, rx_ctrl_next, tx_ctrl_reg, tx_ctrl_next;
  apr_loop_s loop_reg, loop_next;
  logic [3:0] pindir_reg, pindir_next;
  logic [31:0] txbc_reg, txbc_next;
  logic [8:0] rx_slots_reg, rx_slots_next, tx_slots_reg, tx_slots_next;
  logic [11:0] txhf_reg, txhf_next;
  logic txdr_reg, txdr_next, txie_reg, txie_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [4:0] txbc_cnt_reg, txbc_cnt_next;
  logic txbc_out_reg, txbc_out_next, txfs_out_reg, txfs_out_next;
  logic [8:0] slot_cnt_reg, slot_cnt_next;
  apr_half_s rx_seen, tx_seen;
  logic rx_bc_edge, tx_bc_edge, rx_running, tx_running, tx_sr_prev_reg;
  logic wr_en, rd_en, loop_on, from_tx, tx_sr_rise, loop_ok;
  logic rx_clk_sel, rx_fs_sel, hf_sync;

  function automatic logic in_tdm(input logic [8:0] slots);
    in_tdm = (slots >= `APR_TDM_MIN) && (slots <= `APR_TDM_MAX);
  endfunction

  function automatic logic [31:0] pack_global(input apr_half_s rx, input apr_half_s tx);
    pack_global = '0;
    pack_global[4:0] = rx;
    pack_global[`APR_TX_SHIFT +: 5] = tx;
  endfunction

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // loopback needs TDM slot counts on both halves
  assign loop_ok = in_tdm(rx_slots_reg) && in_tdm(tx_slots_reg);
  assign loop_on = loop_reg.enable && loop_ok;
  assign from_tx = loop_on && (loop_reg.mode == `APR_LB_MODE_TX);
  assign rx_clk_sel = from_tx ? tx_bit_clock : rx_bit_clock;
  assign rx_fs_sel = from_tx ? tx_fsync_in : rx_fsync_in;

  genvar g;
  generate
    for (g = 0; g < SERIALIZERS; g = g + 2) begin : g_pair
      always_comb begin
        ser_rx_in[g] = ser_pin_in[g];
        ser_rx_in[g+1] = ser_pin_in[g+1];
        if (loop_on && !loop_reg.order) begin
          ser_rx_in[g] = ser_tx_out[g+1];
        end else if (loop_on) begin
          ser_rx_in[g+1] = ser_tx_out[g];
        end
      end
    end
  endgenerate

  apr_section u_rx (
    .pclk(pclk),
    .presetn(rst_n),
    .bit_clock(rx_clk_sel),
    .frame_sync(rx_fs_sel),
    .fs_rising(1'b1),
    .ctrl(rx_ctrl_reg),
    .seen(rx_seen),
    .bc_edge(rx_bc_edge),
    .frame_start(rx_frame_start),
    .running(rx_running)
  );

  apr_section u_tx (
    .pclk(pclk),
    .presetn(rst_n),
    .bit_clock(tx_bit_clock),
    .frame_sync(tx_fsync_in),
    .fs_rising(1'b1),
    .ctrl(tx_ctrl_reg),
    .seen(tx_seen),
    .bc_edge(tx_bc_edge),
    .frame_start(tx_frame_start),
    .running(tx_running)
  );

  apr_sync #(.WIDTH(1)) u_hf (
    .clk(pclk),
    .rst_n(rst_n),
    .d(tx_hf_clock),
    .q(hf_sync)
  );

  assign tx_sr_rise = tx_seen.sr & ~tx_sr_prev_reg;

  always_comb begin
    rx_ctrl_next = rx_ctrl_reg;
    tx_ctrl_next = tx_ctrl_reg;
    loop_next = loop_reg;
    pindir_next = pindir_reg;
    txbc_next = txbc_reg;
    rx_slots_next = rx_slots_reg;
    tx_slots_next = tx_slots_reg;
    txhf_next = txhf_reg;
    txdr_next = txdr_reg;
    txie_next = txie_reg;
    if (wr_en) begin
      case (paddr)
        `APR_OFF_GLOBAL: begin
          rx_ctrl_next = pwdata[4:0];
          tx_ctrl_next = pwdata[`APR_TX_SHIFT +: 5];
        end
        `APR_OFF_RX_ALIAS: rx_ctrl_next = pwdata[4:0];
        `APR_OFF_TX_ALIAS: tx_ctrl_next = pwdata[`APR_TX_SHIFT +: 5];
        `APR_OFF_LOOPBACK: begin
          loop_next.enable = pwdata[`APR_LB_EN];
          loop_next.order = pwdata[`APR_LB_ORD];
          loop_next.mode = pwdata[`APR_LB_MODE_LO +: 2];
        end
        `APR_OFF_PINDIR: pindir_next = pwdata[3:0];
        `APR_OFF_TXBITCLK: txbc_next = {26'h000_0000, pwdata[5:0]};
        `APR_OFF_RXFSYNC: rx_slots_next = pwdata[15:7];
        `APR_OFF_TXFSYNC: tx_slots_next = pwdata[15:7];
        `APR_OFF_TXHF: txhf_next = pwdata[11:0];
        `APR_OFF_TXSTAT: txie_next = pwdata[16];
        default: begin
        end
      endcase
    end
    // write-one-clear status and buffer writes lose to a fresh release
    if (wr_en && paddr == `APR_OFF_TXSTAT && pwdata[`APR_TXDR_BIT]) begin
      txdr_next = 1'b0;
    end
    if (wr_en && paddr == `APR_OFF_TXBUF) begin
      txdr_next = 1'b0;
    end
    if (tx_sr_rise) begin
      txdr_next = 1'b1;
    end
    if (!tx_seen.sr) begin
      txdr_next = 1'b0;
    end
  end

  always_comb begin
    prdata_next = prdata_reg;
    if (rd_en) begin
      case (paddr)
        // global shows only what the bit-clock side recognised
        `APR_OFF_GLOBAL: prdata_next = pack_global(rx_seen, tx_seen);
        `APR_OFF_RX_ALIAS: prdata_next = pack_global(rx_ctrl_reg, '0);
        `APR_OFF_TX_ALIAS: prdata_next = pack_global('0, tx_ctrl_reg);
        `APR_OFF_LOOPBACK: prdata_next = {28'h000_0000, loop_reg.mode, loop_reg.order,
                                          loop_reg.enable};
        `APR_OFF_PINDIR: prdata_next = {28'h000_0000, pindir_reg};
        `APR_OFF_TXBITCLK: prdata_next = txbc_reg;
        `APR_OFF_RXFSYNC: prdata_next = {16'h0000, rx_slots_reg, 7'h00};
        `APR_OFF_TXFSYNC: prdata_next = {16'h0000, tx_slots_reg, 7'h00};
        `APR_OFF_TXHF: prdata_next = {20'h0_0000, txhf_reg};
        `APR_OFF_TXSTAT: prdata_next = {15'h0000, txie_reg, 10'h000, txdr_reg, 5'h00};
        `APR_OFF_STATE: prdata_next = {30'h0000_0000, tx_running, rx_running};
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  // internal bit clock and frame sync generators; they run while the tx bit clock pin is output and tx_ctrl_reg.bc is set
  always_comb begin
    txbc_cnt_next = txbc_cnt_reg;
    txbc_out_next = txbc_out_reg;
    txfs_out_next = txfs_out_reg;
    slot_cnt_next = slot_cnt_reg;
    if (tx_ctrl_reg.bc && pindir_reg[`APR_PD_TXBC]) begin
      if (txbc_cnt_reg >= txbc_reg[4:0]) begin
        txbc_cnt_next = 5'h00;
        txbc_out_next = ~txbc_out_reg;
        if (txbc_out_reg) begin
          if (slot_cnt_reg >= tx_slots_reg) begin
            slot_cnt_next = 9'h000;
          end else begin
            slot_cnt_next = slot_cnt_reg + 9'h001;
          end
          txfs_out_next = (slot_cnt_reg == 9'h000) && tx_ctrl_reg.fs;
        end
      end else begin
        txbc_cnt_next = txbc_cnt_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ctrl_reg <= '0;
      tx_ctrl_reg <= '0;
      loop_reg <= '0;
      pindir_reg <= 4'h0;
      txbc_reg <= `APR_BC_RESET;
      rx_slots_reg <= 9'h000;
      tx_slots_reg <= 9'h000;
      txhf_reg <= `APR_HF_RESET;
      txdr_reg <= 1'b0;
      txie_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      txbc_cnt_reg <= 5'h00;
      txbc_out_reg <= 1'b0;
      txfs_out_reg <= 1'b0;
      slot_cnt_reg <= 9'h000;
      tx_sr_prev_reg <= 1'b0;
    end else begin
      rx_ctrl_reg <= rx_ctrl_next;
      tx_ctrl_reg <= tx_ctrl_next;
      loop_reg <= loop_next;
      pindir_reg <= pindir_next;
      txbc_reg <= txbc_next;
      rx_slots_reg <= rx_slots_next;
      tx_slots_reg <= tx_slots_next;
      txhf_reg <= txhf_next;
      txdr_reg <= txdr_next;
      txie_reg <= txie_next;
      prdata_reg <= prdata_next;
      txbc_cnt_reg <= txbc_cnt_next;
      txbc_out_reg <= txbc_out_next;
      txfs_out_reg <= txfs_out_next;
      slot_cnt_reg <= slot_cnt_next;
      tx_sr_prev_reg <= tx_seen.sr;
    end
  end

  assign prdata = prdata_reg;
  assign tx_bit_clock_out = txbc_out_reg;
  assign tx_bit_clock_oe_n = ~pindir_reg[`APR_PD_TXBC];
  assign tx_fsync_out = txfs_out_reg;
  assign tx_fsync_oe_n = ~pindir_reg[`APR_PD_TXFS];
  // divide-by-one passes the high-frequency clock regardless of its release bit
  assign tx_hf_clock_gated = (txhf_reg == `APR_HF_RESET) ? hf_sync
                             : (hf_sync & tx_ctrl_reg.hf);
  assign tx_dma_event = txdr_reg;
  assign tx_interrupt = txdr_reg & txie_reg;

  global_lags_alias_a: assert property (@(posedge pclk) disable iff (!rst_n)
    !tx_bc_edge && !rx_bc_edge |=> $stable(rx_seen) && $stable(tx_seen))
    else $error("global readback moved without a bit clock edge");
  alias_immediate_a: assert property (@(posedge pclk) disable iff (!rst_n)
    wr_en && paddr == `APR_OFF_RX_ALIAS |=> rx_ctrl_reg == $past(pwdata[4:0]))
    else $error("alias did not take written value");
  txready_on_release_a: assert property (@(posedge pclk) disable iff (!rst_n)
    tx_sr_rise |=> txdr_reg && tx_dma_event) else $error("tx ready not raised");
  loopback_gate_a: assert property (@(posedge pclk) disable iff (!rst_n)
    !loop_reg.enable |-> ser_rx_in == ser_pin_in) else $error("loopback while disabled");
  loopback_tdm_a: assert property (@(posedge pclk) disable iff (!rst_n)
    !loop_ok |-> !loop_on) else $error("loopback outside tdm slots");
  loop_clock_a: assert property (@(posedge pclk) disable iff (!rst_n)
    from_tx |-> rx_clk_sel == tx_bit_clock && rx_fs_sel == tx_fsync_in)
    else $error("loopback not timed from tx");
  loop_order_a: assert property (@(posedge pclk) disable iff (!rst_n)
    loop_on && !loop_reg.order |-> ser_rx_in[0] == ser_tx_out[1])
    else $error("odd to even loop wrong");
  hf_ungated_a: assert property (@(posedge pclk) disable iff (!rst_n)
    txhf_reg == `APR_HF_RESET |-> tx_hf_clock_gated == hf_sync)
    else $error("divide by one clock gated");
  pin_idle_a: assert property (@(posedge pclk) disable iff (!rst_n)
    !pindir_reg[`APR_PD_TXBC] |=> $stable(txbc_out_reg))
    else $error("bit clock toggled while input");
  tx_frame_c: cover property (@(posedge pclk) disable iff (!rst_n) tx_frame_start);
  rx_loop_frame_c: cover property (@(posedge pclk) disable iff (!rst_n)
    from_tx && rx_frame_start);
  tx_release_c: cover property (@(posedge pclk) disable iff (!rst_n) tx_sr_rise);
endmodule
`default_nettype wire

// ==== sim/apr_codec_model.sv ====
// codec-side model: bit clocks, frame syncs, high-frequency clock and data pins
`timescale 1ns/10ps
`default_nettype none
module apr_codec_model (
  input wire logic run,
  output logic tx_bit_clock,
  output logic rx_bit_clock,
  output logic tx_hf_clock,
  output logic tx_fsync,
  output logic rx_fsync,
  output logic [3:0] ser_pin
);
  int bit_cnt;
  // clocks run before configuration; they stand still only while run is low
  initial begin
    tx_bit_clock = 1'b0;
    rx_bit_clock = 1'b0;
    tx_fsync = 1'b0;
    rx_fsync = 1'b0;
    ser_pin = 4'h3;
    bit_cnt = 0;
    #37;
    forever begin
      #400;
      if (run) begin
        tx_bit_clock = ~tx_bit_clock;
        if (!tx_bit_clock) begin
          bit_cnt = (bit_cnt + 1) % 16;
          tx_fsync = (bit_cnt == 0);
          // data never holds, so a stale value cannot pass for a routed one
          ser_pin = ser_pin + 4'h5;
        end
      end
    end
  end
  // receive side sees the same source through board skew
  always @(tx_bit_clock) rx_bit_clock <= #150 tx_bit_clock;
  always @(tx_fsync) rx_fsync <= #150 tx_fsync;
  initial begin
    tx_hf_clock = 1'b0;
    forever #330 tx_hf_clock = ~tx_hf_clock;
  end
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking bench for the audio port reset and bring-up block
`timescale 1ns/10ps
`default_nettype none
`include "apr_regs.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
  $display("FAIL %0t got %h exp %h", $time, (got), (exp)); end end
module testbench;
  logic pclk, presetn, sleep_reset_n, psel, penable, pwrite, pready, pslverr, codec_run;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic tx_bc, rx_bc, tx_hf, tx_fs, rx_fs, tx_bc_out, tx_bc_oe_n, tx_fs_out, tx_fs_oe_n;
  logic hf_gated, dma_ev, tx_irq, tx_fstart, rx_fstart, hit;
  logic [3:0] ser_pin, ser_tx_out, ser_rx_in;
  int err_total, comparisons;
  apr_codec_model codec (.run(codec_run), .tx_bit_clock(tx_bc), .rx_bit_clock(rx_bc),
    .tx_hf_clock(tx_hf), .tx_fsync(tx_fs), .rx_fsync(rx_fs), .ser_pin(ser_pin));
  apr_top #(.SERIALIZERS(4)) dut (.pclk(pclk), .presetn(presetn),
    .sleep_reset_n(sleep_reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_bit_clock(tx_bc), .rx_bit_clock(rx_bc), .tx_hf_clock(tx_hf), .tx_fsync_in(tx_fs),
    .rx_fsync_in(rx_fs), .ser_pin_in(ser_pin), .ser_tx_out(ser_tx_out),
    .ser_rx_in(ser_rx_in), .tx_bit_clock_out(tx_bc_out), .tx_bit_clock_oe_n(tx_bc_oe_n),
    .tx_fsync_out(tx_fs_out), .tx_fsync_oe_n(tx_fs_oe_n), .tx_hf_clock_gated(hf_gated),
    .tx_dma_event(dma_ev), .tx_interrupt(tx_irq), .tx_frame_start(tx_fstart),
    .rx_frame_start(rx_fstart));
  always #50 pclk = ~pclk;
  task automatic close_out;
    if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      close_out;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  // bounded poll: a stopped bit clock must not hang the run
  task automatic poll_global(input logic [31:0] exp);
    int n;
    n = 0;
    rd(`APR_OFF_GLOBAL);
    while (q !== exp && n < 60) begin
      rd(`APR_OFF_GLOBAL);
      n++;
    end
    `CHK(q, exp)
    if (q !== exp) close_out;
  endtask
  task automatic watch(input int sel, input int cycles);
    logic s;
    hit = 1'b0;
    for (int n = 0; n < cycles; n++) begin
      @(posedge pclk);
      #1;
      case (sel)
        0: s = hf_gated;
        1: s = tx_bc_out;
        2: s = tx_fstart;
        3: s = tx_fs_out;
        default: s = dma_ev;
      endcase
      if (s === 1'b1) hit = 1'b1;
    end
  endtask
  task automatic t_reset_values;
    @(posedge pclk);
    #1;
    `CHK(tx_bc_oe_n, 1'b1)
    rd(`APR_OFF_GLOBAL);
    `CHK(q, 32'h0000_0000)
    rd(`APR_OFF_TXBITCLK);
    `CHK(q, `APR_BC_RESET)
    rd(`APR_OFF_TXHF);
    `CHK(q[11:0], `APR_HF_RESET)
    wr(12'h3F0, 32'hFFFF_FFFF);
    rd(12'h3F0);
    `CHK(q, 32'h0000_0000)
    `CHK(pslverr, 1'b0)
    wr(`APR_OFF_GLOBAL, 32'h0000_0000);
  endtask
  task automatic t_hf_divider;
    watch(0, 40);
    `CHK(hit, 1'b1)
    wr(`APR_OFF_TXHF, 32'h0000_0001);
    watch(0, 10);
    watch(0, 40);
    `CHK(hit, 1'b0)
    wr(`APR_OFF_TXHF, 32'h0000_0000);
  endtask
  // bit clock held still so the lag of the global read-back is certain
  task automatic t_release_hf;
    codec_run <= 1'b0;
    repeat (10) @(posedge pclk);
    wr(`APR_OFF_TX_ALIAS, 32'h0000_0100);
    rd(`APR_OFF_GLOBAL);
    `CHK(q, 32'h0000_0000)
    rd(`APR_OFF_TX_ALIAS);
    `CHK(q, 32'h0000_0100)
    wr(`APR_OFF_RX_ALIAS, 32'h0000_0001);
    rd(`APR_OFF_RX_ALIAS);
    `CHK(q, 32'h0000_0001)
    rd(`APR_OFF_GLOBAL);
    `CHK(q, 32'h0000_0000)
    codec_run <= 1'b1;
    poll_global(32'h0000_0101);
  endtask
  task automatic t_stopped_clock;
    codec_run <= 1'b0;
    repeat (20) @(posedge pclk);
    wr(`APR_OFF_GLOBAL, 32'h0000_0303);
    repeat (60) @(posedge pclk);
    rd(`APR_OFF_GLOBAL);
    `CHK(q, 32'h0000_0101)
    codec_run <= 1'b1;
    poll_global(32'h0000_0303);
  endtask
  task automatic t_pin_dir;
    wr(`APR_OFF_PINDIR, 32'h0000_0003);
    @(posedge pclk);
    #1;
    `CHK({tx_bc_oe_n, tx_fs_oe_n}, 2'b00)
    watch(1, 200);
    `CHK(hit, 1'b1)
  endtask
  task automatic t_serializer;
    wr(`APR_OFF_TXSTAT, 32'h0001_FFFF);
    wr(`APR_OFF_GLOBAL, 32'h0000_0707);
    poll_global(32'h0000_0707);
    watch(5, 20);
    `CHK({dma_ev, tx_irq}, 2'b11)
    rd(`APR_OFF_TXSTAT);
    `CHK(q[`APR_TXDR_BIT], 1'b1)
    wr(`APR_OFF_TXBUF, 32'h1234_5678);
    @(posedge pclk);
    #1;
    `CHK({dma_ev, tx_irq}, 2'b00)
  endtask
  task automatic t_frame;
    wr(`APR_OFF_GLOBAL, 32'h0000_0F0F);
    poll_global(32'h0000_0F0F);
    watch(2, 200);
    `CHK(hit, 1'b0)
    wr(`APR_OFF_GLOBAL, 32'h0000_1F1F);
    watch(2, 300);
    `CHK(hit, 1'b1)
    watch(3, 40);
    `CHK(hit, 1'b1)
    poll_global(32'h0000_1F1F);
    rd(`APR_OFF_STATE);
    `CHK(q[1], 1'b1)
    `CHK(q[0], 1'b1)
  endtask
  // routing is looked at once the loopback write has landed
  task automatic t_loopback;
    wr(`APR_OFF_TXBITCLK, 32'h0000_0000);
    wr(`APR_OFF_RXFSYNC, 32'h0000_0100);
    wr(`APR_OFF_TXFSYNC, 32'h0000_1000);
    ser_tx_out <= 4'hA;
    wr(`APR_OFF_LOOPBACK, 32'h0000_0004);
    #1;
    `CHK(ser_rx_in, ser_pin)
    wr(`APR_OFF_LOOPBACK, 32'h0000_0005);
    #1;
    `CHK({ser_rx_in[2], ser_rx_in[0]}, 2'b11)
    ser_tx_out <= 4'h6;
    wr(`APR_OFF_LOOPBACK, 32'h0000_0007);
    #1;
    `CHK({ser_rx_in[3], ser_rx_in[1]}, 2'b10)
    wr(`APR_OFF_RXFSYNC, 32'h0000_1080);
    #1;
    `CHK(ser_rx_in, ser_pin)
    wr(`APR_OFF_RXFSYNC, 32'h0000_0080);
    #1;
    `CHK(ser_rx_in, ser_pin)
  endtask
  task automatic t_sleep_reset;
    sleep_reset_n <= 1'b0;
    repeat (2) @(posedge pclk);
    sleep_reset_n <= 1'b1;
    @(posedge pclk);
    #1;
    `CHK({dma_ev, tx_bc_oe_n}, 2'b01)
    rd(`APR_OFF_GLOBAL);
    `CHK(q, 32'h0000_0000)
    rd(`APR_OFF_TXBITCLK);
    `CHK(q, `APR_BC_RESET)
    rd(`APR_OFF_LOOPBACK);
    `CHK(q, 32'h0000_0000)
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    sleep_reset_n = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    ser_tx_out = 4'h0;
    codec_run = 1'b1;
    err_total = 0;
    comparisons = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values;
    t_hf_divider;
    t_release_hf;
    t_stopped_clock;
    t_pin_dir;
    t_serializer;
    t_frame;
    t_loopback;
    t_sleep_reset;
    close_out;
  end
  initial begin
    #9000000;
    err_total++;
    close_out;
  end
endmodule
`default_nettype wire
